// File: hw/dcd_map.svh
// register offsets, field positions, reset values and timing figures of the pacer
`ifndef DCD_MAP_SVH
`define DCD_MAP_SVH
`define DCD_OFS_CTRL 8'h00
`define DCD_OFS_STATE 8'h04
`define DCD_OFS_IRQ_STAT 8'h08
`define DCD_OFS_IRQ_MASK 8'h0c
`define DCD_CTRL_EOT 0
`define DCD_CTRL_FLOW 1
`define DCD_CTRL_BUF 2
`define DCD_CTRL_RESET 3'h4
`define DCD_IRQ_OVERRUN 0
`define DCD_IRQ_TIMEOUT 1
`define DCD_IRQ_CLOSED 2
`define DCD_IRQ_DONE 3
`define DCD_CHAR_ETX 8'h03
`define DCD_CLK_HZ 125000000
`define DCD_RECOVER_MS 350
`define DCD_OUT_MAX_S 14
`define DCD_BUF_DEPTH 1024
`endif

// File: hw/dcd_pkg.sv
// types shared by the pacer modules
package dcd_pkg;
	typedef enum logic [3:0] {
		CMD_ENTER, CMD_ENTER_AUTO, CMD_RECEIVE, CMD_RECEIVE_AUTO,
		CMD_DISPLAY, CMD_SEND, CMD_PRINT, CMD_DIRECTORY,
		CMD_STATUS, CMD_RESET
	} dcd_cmd_type;
	typedef enum logic [2:0] {
		ST_IDLE, ST_LOOKUP, ST_RECEIVE, ST_CLOSE,
		ST_FETCH, ST_OUTPUT, ST_STATUS, ST_RECOVER
	} dcd_state_type;
endpackage

// File: hw/dcd_stream_if.sv
// valid/ready byte stream between the pacer and its hold buffer
`timescale 1ns/1ps
`default_nettype none
interface dcd_stream_if #(parameter int WIDTH = 8);
	logic valid;
	logic ready;
	logic [WIDTH-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// File: hw/dcd_hold_buf.sv
// flip-flop fifo that holds received bytes while the disk is busy
`timescale 1ns/1ps
`default_nettype none
module dcd_hold_buf #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 1024
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	input wire logic flush,
	// fill and drain sides
	dcd_stream_if.snk up,
	dcd_stream_if.src down
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic push;
	logic pop;

	// honest full and empty
	assign up.ready = (count != (AW+1)'(DEPTH));
	assign down.valid = (count != '0);
	assign down.data = mem[rd_ptr];
	assign push = up.valid && up.ready;
	assign pop = down.valid && down.ready;

	// storage, no reset needed
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_ptr] <= up.data;
		end
	end

	// pointers and fill count
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else if (flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			if (push) begin
				wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
			end
			count <= count + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	// every accepted byte is counted once, never past the depth
	property p_no_overfill;
		@(posedge clk) disable iff (!rst_b)
		(!flush && push && !pop) |=> (count == $past(count) + 1'b1) && (count <= (AW+1)'(DEPTH));
	endproperty
	a_no_overfill: assert property (p_no_overfill) else $error("hold buffer overfilled");
endmodule
`default_nettype wire

// File: hw/dcd_pacer.sv
// command pacing and ready indications of the disk file store
//
// Overview of operation
// - store/receive commands do directory look-up first
// - terminal origin: withhold CR/LF until ready
// - modem origin: prompt only after look-up
// - ETX closes file; terminal gets bell
// - setting 2 sends EOT on modem completion
// - status answered only after file close
// - reset aborts status; idle after 350 ms
// - output starts within 14 s of command
// - directory output may pause midway
// - new command accepted right after output
// - lost bytes flag overrun error
// - flow control sends stop then start
// - buffer option stores data during look-up
//
// The address map and the address-and-strobe port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "dcd_map.svh"
module dcd_pacer #(
	parameter int unsigned RECOVER_CYC = `DCD_RECOVER_MS * (`DCD_CLK_HZ / 1000),
	parameter int unsigned OUT_MAX_CYC = 32'(64'(`DCD_OUT_MAX_S) * 64'(`DCD_CLK_HZ)),
	parameter int BUF_DEPTH = `DCD_BUF_DEPTH
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	output logic irq,
	// command in from the port parser
	input wire logic cmd_valid,
	input wire dcd_pkg::dcd_cmd_type cmd_code,
	input wire logic cmd_from_modem,
	output logic cmd_ready,
	// received file bytes
	input wire logic rx_valid,
	input wire logic [7:0] rx_data,
	// disk side
	output logic lookup_req,
	input wire logic lookup_done,
	output logic close_req,
	input wire logic close_done,
	output logic fetch_req,
	input wire logic fetch_ready,
	input wire logic search_error,
	output logic store_valid,
	output logic [7:0] store_data,
	input wire logic store_ready,
	// output side
	output logic out_start,
	input wire logic out_last,
	output logic status_start,
	output logic status_abort,
	input wire logic status_done,
	// ready indications
	output logic crlf_send,
	output logic prompt_send,
	output logic bell_send,
	output logic eot_send,
	output logic xoff_send,
	output logic xon_send
);
	import dcd_pkg::*;
	// ************************************************
	// helpers
	// ************************************************
	function automatic logic is_store_cmd(input dcd_cmd_type c);
		return (c == CMD_ENTER) || (c == CMD_ENTER_AUTO) ||
			(c == CMD_RECEIVE) || (c == CMD_RECEIVE_AUTO);
	endfunction
	function automatic logic is_out_cmd(input dcd_cmd_type c);
		return (c == CMD_DISPLAY) || (c == CMD_SEND) ||
			(c == CMD_PRINT) || (c == CMD_DIRECTORY);
	endfunction
	dcd_state_type state;
	logic [2:0] ctrl;
	logic [3:0] irq_stat;
	logic [3:0] irq_mask;
	logic [3:0] irq_set;
	logic origin_modem;
	logic etx_seen;
	logic stopped;
	logic [31:0] rec_cnt;
	logic [31:0] wait_cnt;
	logic take_cmd;
	logic take_reset;
	logic rx_state;
	logic rx_ok;
	logic is_etx;
	logic lost;
	logic timeout;
	logic stop_need;
	logic done_evt;
	dcd_stream_if #(.WIDTH(8)) fill_if ();
	dcd_stream_if #(.WIDTH(8)) drain_if ();
	// ************************************************
	// register port
	// ************************************************
	// control bits: eot enable, flow control, buffering
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ctrl <= `DCD_CTRL_RESET;
			irq_mask <= 4'h0;
		end else if (reg_wr) begin
			if (reg_addr == `DCD_OFS_CTRL) begin
				ctrl <= reg_wdata[2:0];
			end
			if (reg_addr == `DCD_OFS_IRQ_MASK) begin
				irq_mask <= reg_wdata[3:0];
			end
		end
	end
	// sticky events, write one clears, set wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_stat <= 4'h0;
		end else begin
			irq_stat <= (irq_stat & ~((reg_wr && reg_addr == `DCD_OFS_IRQ_STAT) ?
				reg_wdata[3:0] : 4'h0)) | irq_set;
		end
	end
	// read data one cycle after the strobe, unmapped reads zero
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			reg_rdata <= 32'h0;
		end else if (reg_rd) begin
			case (reg_addr)
				`DCD_OFS_CTRL: reg_rdata <= {29'h0, ctrl};
				`DCD_OFS_STATE: reg_rdata <= {25'h0, stopped, etx_seen, origin_modem,
					cmd_ready, state};
				`DCD_OFS_IRQ_STAT: reg_rdata <= {28'h0, irq_stat};
				`DCD_OFS_IRQ_MASK: reg_rdata <= {28'h0, irq_mask};
				default: reg_rdata <= 32'h0;
			endcase
		end else begin
			reg_rdata <= 32'h0;
		end
	end
	assign irq = |(irq_stat & irq_mask);
	assign irq_set = {done_evt, close_done && state == ST_CLOSE, timeout, lost};
	// ************************************************
	// command acceptance
	// ************************************************
	assign cmd_ready = (state == ST_IDLE);
	assign take_cmd = cmd_valid && cmd_ready;
	assign take_reset = cmd_valid && cmd_code == CMD_RESET &&
		(state == ST_IDLE || state == ST_STATUS || state == ST_FETCH || state == ST_OUTPUT);
	assign timeout = (state == ST_FETCH) && !fetch_ready && (wait_cnt == OUT_MAX_CYC - 1);
	assign done_evt = (state == ST_OUTPUT && out_last) ||
		(state == ST_STATUS && status_done) || (state == ST_CLOSE && close_done);
	// main sequence
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			origin_modem <= 1'b0;
		end else if (take_reset) begin
			state <= ST_RECOVER;
		end else begin
			case (state)
				ST_IDLE: begin
					if (take_cmd) begin
						origin_modem <= cmd_from_modem;
						if (is_store_cmd(cmd_code)) begin
							state <= ST_LOOKUP;
						end else if (is_out_cmd(cmd_code)) begin
							state <= ST_FETCH;
						end else if (cmd_code == CMD_STATUS) begin
							state <= ST_STATUS;
						end
					end
				end
				ST_LOOKUP: if (lookup_done) begin
					state <= ST_RECEIVE;
				end
				ST_RECEIVE: if (etx_seen && !drain_if.valid) begin
					state <= ST_CLOSE;
				end
				ST_CLOSE: if (close_done) begin
					state <= ST_IDLE;
				end
				ST_FETCH: begin
					if (fetch_ready) begin
						state <= ST_OUTPUT;
					end else if (timeout) begin
						state <= ST_IDLE;
					end
				end
				// directory output may stall here for any time
				ST_OUTPUT: if (out_last) begin
					state <= ST_IDLE;
				end
				ST_STATUS: if (status_done) begin
					state <= ST_IDLE;
				end
				ST_RECOVER: if (rec_cnt == RECOVER_CYC - 1) begin
					state <= ST_IDLE;
				end
				default: state <= ST_IDLE;
			endcase
		end
	end
	// reset recovery and output deadline counters
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rec_cnt <= 32'h0;
			wait_cnt <= 32'h0;
		end else begin
			rec_cnt <= (state == ST_RECOVER && !take_reset) ? rec_cnt + 32'h1 : 32'h0;
			wait_cnt <= (state == ST_FETCH) ? wait_cnt + 32'h1 : 32'h0;
		end
	end
	// ************************************************
	// one-cycle requests and ready indications
	// ************************************************
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			lookup_req <= 1'b0;
			fetch_req <= 1'b0;
			close_req <= 1'b0;
			status_start <= 1'b0;
			status_abort <= 1'b0;
			out_start <= 1'b0;
			crlf_send <= 1'b0;
			prompt_send <= 1'b0;
			bell_send <= 1'b0;
			eot_send <= 1'b0;
		end else begin
			lookup_req <= take_cmd && is_store_cmd(cmd_code);
			fetch_req <= take_cmd && is_out_cmd(cmd_code);
			status_start <= take_cmd && cmd_code == CMD_STATUS;
			status_abort <= take_reset && state == ST_STATUS;
			close_req <= state == ST_RECEIVE && etx_seen && !drain_if.valid;
			out_start <= state == ST_FETCH && fetch_ready && !take_reset;
			crlf_send <= state == ST_LOOKUP && lookup_done && !origin_modem;
			prompt_send <= state == ST_LOOKUP && lookup_done && origin_modem;
			bell_send <= state == ST_CLOSE && close_done && !origin_modem;
			eot_send <= done_evt && origin_modem && ctrl[`DCD_CTRL_EOT] && !take_reset;
		end
	end
	// ************************************************
	// receive path
	// ************************************************
	assign rx_state = (state == ST_LOOKUP) || (state == ST_RECEIVE);
	assign is_etx = (rx_data == `DCD_CHAR_ETX);
	// without buffering only the receive state with a healthy disk takes data
	assign rx_ok = ctrl[`DCD_CTRL_BUF] ? fill_if.ready :
		(state == ST_RECEIVE && !search_error && fill_if.ready);
	assign fill_if.valid = rx_valid && rx_state && !etx_seen && !is_etx && rx_ok;
	assign fill_if.data = rx_data;
	assign lost = rx_valid && rx_state && !etx_seen && !is_etx && !rx_ok;
	assign drain_if.ready = (state == ST_RECEIVE) && store_ready && !search_error;
	dcd_hold_buf #(.WIDTH(8), .DEPTH(BUF_DEPTH)) u_hold (
		.clk(clk),
		.rst_b(rst_b),
		.flush(state == ST_IDLE),
		.up(fill_if),
		.down(drain_if)
	);
	// end of text marks the file for close-out
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			etx_seen <= 1'b0;
		end else if (!rx_state) begin
			etx_seen <= 1'b0;
		end else if (rx_valid && is_etx) begin
			etx_seen <= 1'b1;
		end
	end
	// bytes handed to the disk writer
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			store_valid <= 1'b0;
			store_data <= 8'h00;
		end else begin
			store_valid <= drain_if.valid && drain_if.ready;
			if (drain_if.valid && drain_if.ready) begin
				store_data <= drain_if.data;
			end
		end
	end
	// ************************************************
	// stop/start flow control
	// ************************************************
	assign stop_need = rx_state && (search_error || !fill_if.ready);
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			stopped <= 1'b0;
			xoff_send <= 1'b0;
			xon_send <= 1'b0;
		end else begin
			xoff_send <= 1'b0;
			xon_send <= 1'b0;
			if (ctrl[`DCD_CTRL_FLOW] && stop_need && !stopped) begin
				stopped <= 1'b1;
				xoff_send <= 1'b1;
			end else if (stopped && !stop_need && !drain_if.valid) begin
				stopped <= 1'b0;
				xon_send <= 1'b1;
			end
		end
	end
	// ************************************************
	// checks
	// ************************************************
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);
	property p_store_after_lookup;
		store_valid |-> $past(state) == ST_RECEIVE;
	endproperty
	a_store_after_lookup: assert property (p_store_after_lookup) else $error("stored before look-up");
	property p_crlf;
		(state == ST_LOOKUP && lookup_done && !origin_modem && !take_reset) |=> crlf_send && !prompt_send;
	endproperty
	a_crlf: assert property (p_crlf) else $error("cr/lf not sent at look-up end");
	property p_prompt;
		prompt_send |-> $past(lookup_done) && $past(state) == ST_LOOKUP && origin_modem;
	endproperty
	a_prompt: assert property (p_prompt) else $error("prompt sent before look-up end");
	property p_bell;
		bell_send |-> $past(close_done) && $past(state) == ST_CLOSE && !origin_modem;
	endproperty
	a_bell: assert property (p_bell) else $error("bell without close-out");
	property p_eot;
		eot_send |-> $past(ctrl[`DCD_CTRL_EOT]) && origin_modem && state == ST_IDLE;
	endproperty
	a_eot: assert property (p_eot) else $error("eot sent while disabled");
	property p_status;
		status_start |-> $past(state) == ST_IDLE && state == ST_STATUS;
	endproperty
	a_status: assert property (p_status) else $error("status answered while busy");
	property p_reset;
		(take_reset && state == ST_STATUS) |=> status_abort && state == ST_RECOVER;
	endproperty
	a_reset: assert property (p_reset) else $error("reset did not abort status");
	property p_recover;
		state == ST_RECOVER |-> rec_cnt < RECOVER_CYC;
	endproperty
	a_recover: assert property (p_recover) else $error("recovery overstayed");
	property p_deadline;
		state == ST_FETCH |-> wait_cnt < OUT_MAX_CYC;
	endproperty
	a_deadline: assert property (p_deadline) else $error("output deadline missed");
	property p_next_cmd;
		(state == ST_OUTPUT && out_last && !take_reset) |=> cmd_ready;
	endproperty
	a_next_cmd: assert property (p_next_cmd) else $error("not ready after last char");
	property p_overrun;
		lost |=> irq_stat[`DCD_IRQ_OVERRUN];
	endproperty
	a_overrun: assert property (p_overrun) else $error("lost byte not flagged");
	property p_xoff;
		(ctrl[`DCD_CTRL_FLOW] && stop_need && !stopped && !take_reset) |=> xoff_send ##1 !xoff_send;
	endproperty
	a_xoff: assert property (p_xoff) else $error("stop character missing");
	c_receive: cover property (state == ST_CLOSE && close_done);
	c_output: cover property (state == ST_OUTPUT && out_last);
	c_abort: cover property (status_abort);
	c_flow: cover property (xoff_send ##[1:200] xon_send);
endmodule
`default_nettype wire

// File: tb/dcd_disk_model.sv
// disk drive and output engine model facing the pacer
`timescale 1ns/1ps
`default_nettype none
module dcd_disk_model (
	// clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// requests from the pacer
	input wire logic lookup_req,
	input wire logic close_req,
	input wire logic fetch_req,
	input wire logic out_start,
	input wire logic status_start,
	input wire logic status_abort,
	// bench knobs: answer latency, fetch never answered
	input wire logic [7:0] lat,
	input wire logic mute,
	// answers
	output logic lookup_done,
	output logic close_done,
	output logic fetch_ready,
	output logic out_last,
	output logic status_done,
	output logic store_ready
);
	logic [7:0] cnt;
	logic [2:0] job;
	logic [4:0] ans;
	logic [4:0] req;
	assign req = {status_start, out_start, fetch_req, close_req, lookup_req};
	assign {status_done, out_last, fetch_ready, close_done, lookup_done} = ans;
	assign store_ready = !mute;
	// one job at a time, answered by a pulse after lat cycles; status_abort drops the job, mute holds a fetch
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			ans <= 5'h0;
			job <= 3'h0;
			cnt <= 8'h0;
		end else begin
			ans <= 5'h0;
			if (req != 5'h0) begin
				job <= req[0] ? 3'h1 : req[1] ? 3'h2 : req[2] ? 3'h3 : req[3] ? 3'h4 : 3'h5;
				cnt <= lat;
			end else if (status_abort) begin
				job <= 3'h0;
			end else if (job != 3'h0 && !(mute && job == 3'h3)) begin
				if (cnt != 8'h0) begin
					cnt <= cnt - 8'h1;
				end else begin
					ans <= 5'h1 << (job - 3'h1);
					job <= 3'h0;
				end
			end
		end
	end
endmodule
`default_nettype wire

// File: tb/dcd_pacer_tb.sv
// self-checking bench of the command pacer
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
$display("ERROR %s expected %0h seen %0h", nm, e, g); end end
module dcd_pacer_tb;
	import dcd_pkg::*;
	localparam int RCV = 20;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [7:0] reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic cmd_valid = 1'b0;
	dcd_cmd_type cmd_code = CMD_ENTER;
	logic cmd_from_modem = 1'b0;
	logic rx_valid = 1'b0;
	logic [7:0] rx_data = 8'h0;
	logic search_error = 1'b0;
	logic [7:0] lat = 8'ha;
	logic mute = 1'b0;
	logic [31:0] reg_rdata;
	logic [7:0] store_data;
	logic irq, cmd_ready, lookup_req, lookup_done, close_req, close_done, fetch_req, fetch_ready;
	logic store_valid, store_ready, out_start, out_last, status_start, status_abort, status_done;
	logic crlf_send, prompt_send, bell_send, eot_send, xoff_send, xon_send;
	logic [31:0] v;
	logic [10:0] pv;
	int n[11];
	int fail_count = 0;
	int total_checks = 0;
	int eot_on = 0;
	int k, cyc, tl, nr;
	logic [7:0] exp_q[$];
	logic [7:0] got_q[$];
	dcd_cmd_type op[4] = '{CMD_DISPLAY, CMD_SEND, CMD_PRINT, CMD_DIRECTORY};

	dcd_pacer #(.RECOVER_CYC(RCV), .OUT_MAX_CYC(50), .BUF_DEPTH(4)) dcd_pacer_inst (.clk(clk), .rst_b(rst_b),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.irq(irq), .cmd_valid(cmd_valid), .cmd_code(cmd_code), .cmd_from_modem(cmd_from_modem),
		.cmd_ready(cmd_ready), .rx_valid(rx_valid), .rx_data(rx_data), .lookup_req(lookup_req),
		.lookup_done(lookup_done), .close_req(close_req), .close_done(close_done), .fetch_req(fetch_req),
		.fetch_ready(fetch_ready), .search_error(search_error), .store_valid(store_valid),
		.store_data(store_data), .store_ready(store_ready), .out_start(out_start), .out_last(out_last),
		.status_start(status_start), .status_abort(status_abort), .status_done(status_done),
		.crlf_send(crlf_send), .prompt_send(prompt_send), .bell_send(bell_send), .eot_send(eot_send),
		.xoff_send(xoff_send), .xon_send(xon_send));
	dcd_disk_model dcd_disk_model_inst (.clk(clk), .rst_b(rst_b), .lookup_req(lookup_req),
		.close_req(close_req), .fetch_req(fetch_req), .out_start(out_start), .status_start(status_start),
		.status_abort(status_abort), .lat(lat), .mute(mute), .lookup_done(lookup_done),
		.close_done(close_done), .fetch_ready(fetch_ready), .out_last(out_last),
		.status_done(status_done), .store_ready(store_ready));

	always #4 clk = ~clk;
	// pulse counters and stored bytes, the bench's view of the outputs
	assign pv = {status_abort, status_start, out_start, fetch_req, lookup_req, xon_send, xoff_send,
		eot_send, bell_send, prompt_send, crlf_send};
	always @(posedge clk) begin
		cyc++;
		if (out_last === 1'b1) tl = cyc;
		foreach (n[i]) n[i] += int'(pv[i] === 1'b1);
		if (store_valid === 1'b1 && store_ready === 1'b1) got_q.push_back(store_data);
	end

	task automatic clr;
		@(negedge clk);
		foreach (n[i]) n[i] = 0;
		exp_q.delete();
		got_q.delete();
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		@(posedge clk);
		d = reg_rdata;
	endtask
	// command held until taken; reset is held one cycle and is taken only in the idle, status, fetch and output states
	task automatic cmd(input dcd_cmd_type c, input logic m);
		int j;
		@(posedge clk);
		cmd_valid <= 1'b1;
		cmd_code <= c;
		cmd_from_modem <= m;
		for (j = 0; j < 100; j++) begin
			@(posedge clk);
			if (cmd_ready === 1'b1 || c == CMD_RESET) break;
		end
		// a command never taken is a failure
		if (j == 100) fail_count++;
		cmd_valid <= 1'b0;
	endtask
	task automatic wait_ready(output int c);
		for (c = 0; c < 300; c++) begin
			@(posedge clk);
			if (cmd_ready === 1'b1) break;
		end
		// a port that never frees up is a failure
		if (c == 300) fail_count++;
		// let the pulse counters of this edge settle
		@(negedge clk);
	endtask
	task automatic tx(input logic [7:0] d);
		@(posedge clk);
		rx_valid <= 1'b1;
		rx_data <= d;
		@(posedge clk);
		rx_valid <= 1'b0;
	endtask
	// receive: bytes right after the command, wait for the ready sign, etx
	task automatic recv(input logic m, input int nb, input int keep, input int se);
		logic [7:0] b;
		int j;
		clr;
		// walk through all four store commands in turn
		cmd(dcd_cmd_type'(4'(nr % 4)), m);
		nr++;
		for (j = 0; j < nb; j++) begin
			b = 8'($urandom_range(255, 16));
			if (keep != 0) exp_q.push_back(b);
			tx(b);
		end
		for (j = 0; j < 100 && n[0] + n[1] == 0; j++) @(posedge clk);
		search_error <= (se != 0);
		repeat (4) @(posedge clk);
		search_error <= 1'b0;
		tx(8'h03);
		wait_ready(j);
		`CHK("lookup", 1, n[6])
		`CHK("crlf", int'(!m), n[0])
		`CHK("prompt", int'(m), n[1])
		`CHK("bell", int'(!m), n[2])
		`CHK("eot", int'(m) * eot_on, n[3])
		`CHK("xoff", se, n[4])
		`CHK("xon", se, n[5])
		`CHK("stored", exp_q.size(), got_q.size())
		foreach (exp_q[i]) `CHK("byte", exp_q[i], got_q[i])
	endtask
	task automatic final_report;
		$display("checks %0d mismatches %0d", total_checks, fail_count);
		if (fail_count == 0 && total_checks > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	initial begin
		void'($urandom(85));
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		// reset values, read-only state, unmapped place
		rd(8'h00, v);
		`CHK("ctrl", 32'h4, v)
		wr(8'h04, 32'h7);
		rd(8'h04, v);
		`CHK("state", 32'h8, v)
		rd(8'h0c, v);
		`CHK("mask", 32'h0, v)
		wr(8'h10, 32'hf);
		rd(8'h10, v);
		`CHK("unmapped", 32'h0, v)
		$display("test registers done");
		// buffered receive from the terminal, then from the modem with eot; bursts fit the hold depth
		recv(1'b0, 3, 1, 0);
		rd(8'h08, v);
		`CHK("closed", 32'hc, v & 32'hc)
		wr(8'h08, 32'hf);
		rd(8'h08, v);
		`CHK("cleared", 32'h0, v)
		wr(8'h00, 32'h5);
		eot_on = 1;
		recv(1'b1, 3, 1, 0);
		// unbuffered: a byte during look-up is lost
		wr(8'h00, 32'h1);
		recv(1'b1, 1, 0, 0);
		rd(8'h08, v);
		`CHK("overrun", 32'h1, v & 32'h1)
		// flow control around a search error
		wr(8'h00, 32'h6);
		eot_on = 0;
		recv(1'b0, 0, 1, 1);
		wr(8'h08, 32'hf);
		$display("test receive, overrun and flow done");
		// output commands back to back with random disk latency
		foreach (op[i]) begin
			clr;
			lat <= 8'($urandom_range(20, 1));
			cmd(op[i], 1'(i % 2));
			wait_ready(k);
			`CHK("fetch", 1, n[7])
			`CHK("start", 1, n[8])
			`CHK("latency", 1, int'(k < 60))
			`CHK("gap", 1, int'(cyc - tl <= 2))
		end
		// a fetch that never answers ends in a masked, then unmasked timeout
		clr;
		mute <= 1'b1;
		cmd(CMD_SEND, 1'b0);
		wait_ready(k);
		`CHK("no output", 0, n[8])
		rd(8'h08, v);
		`CHK("timeout", 32'h2, v & 32'h2)
		`CHK("masked", 1'b0, irq)
		wr(8'h0c, 32'h2);
		@(negedge clk);
		`CHK("irq", 1'b1, irq)
		wr(8'h08, 32'hf);
		@(negedge clk);
		`CHK("irq clear", 1'b0, irq)
		wr(8'h0c, 32'h0);
		mute <= 1'b0;
		// reset aborts a slow status output, then recovery
		clr;
		lat <= 8'h28;
		cmd(CMD_STATUS, 1'b1);
		repeat (5) @(posedge clk);
		cmd(CMD_RESET, 1'b1);
		wait_ready(k);
		`CHK("status", 1, n[9])
		`CHK("abort", 1, n[10])
		`CHK("recover", 1, int'(k >= RCV - 1 && k <= RCV + 3))
		$display("test output, timeout and reset done");
		final_report;
	end
	// watchdog: the tests need under 2000 cycles, this allows 25000 (200000 ns at 8 ns per cycle)
	initial begin
		#200000;
		fail_count++;
		final_report;
	end
endmodule
`default_nettype wire
